// [verilog/symctr_defines.svh]
`ifndef SYMCTR_DEFINES_SVH
`define SYMCTR_DEFINES_SVH

// register byte addresses
`define SYMCTR_ADDR_W 8
`define SYMCTR_ADDR_CTRL 8'hDD
`define SYMCTR_ADDR_STATUS 8'hDE
`define SYMCTR_ADDR_IRQ_MASK 8'hDF
`define SYMCTR_ADDR_IRQ_STATUS 8'hE0

// control register fields
`define CTRL_BACKOFF_EN_BIT 0
`define CTRL_EXT_CLK_EN_BIT 1
`define CTRL_PRESCALE_LSB 2
`define CTRL_PRESCALE_MSB 4
`define CTRL_CLK_SRC_SEL_BIT 6

// status register fields
`define STATUS_WRITE_PENDING_BIT 0

// interrupt status and mask fields
`define IRQ_COMPARE1_BIT 0
`define IRQ_COMPARE2_BIT 1
`define IRQ_COMPARE3_BIT 2
`define IRQ_OVERFLOW_BIT 3
`define IRQ_BACKOFF_BIT 4
`define IRQ_COUNT 5

// reset values
`define CTRL_RESET 8'h00
`define IRQ_MASK_RESET 5'h00
`define IRQ_STATUS_RESET 5'h00
`define PRESCALE_RESET 3'h0

// timing
`define XTAL_FREQ_KHZ 16000
`define PRESCALE_DIV_MAX 256
`define BACKOFF_SLOT_US 320
`define SYMBOL_PERIOD_US 16
`define BACKOFF_SLOT_SYMBOLS (`BACKOFF_SLOT_US / `SYMBOL_PERIOD_US)

`endif

// [verilog/symctr_pkg.sv]
package symctr_pkg;

  // one bit per event, ordered as in the status and mask registers
  typedef struct packed {
    logic backoff;
    logic overflow;
    logic compare3;
    logic compare2;
    logic compare1;
  } irq_vec_t;

  typedef struct packed {
    logic clock_source_select;
    logic [2:0] tick_prescale_code;
    logic ext_clock_enable;
    logic backoff_enable;
  } ctrl_t;

  typedef enum logic [1:0] {
    SRC_XTAL,
    SRC_RTC,
    SRC_EXT
  } tick_src_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : symctr_pkg

// [verilog/tick_prescaler.sv]
`timescale 1ns/1ps
`include "symctr_defines.svh"

module tick_prescaler #(
  parameter int DIV_MAX = `PRESCALE_DIV_MAX
) (
  // clock and control
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // transceiver clock cycle pulses and divider code
  input wire logic xtal_pulse_i,
  input wire logic [2:0] code_i,
  // one pulse per divided period
  output logic tick_o
);
  localparam int CNT_W = $clog2(DIV_MAX);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic tick;
  } presc_state_t;

  presc_state_t st_r;
  presc_state_t st_nxt;
  logic [CNT_W-1:0] last;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    // code 7 is not defined; it falls back to the fastest division
    if (code_i == 3'h7) begin
      last = CNT_W'((DIV_MAX >> 6) - 1);
    end else begin
      last = CNT_W'((DIV_MAX >> code_i) - 1);
    end
    if (xtal_pulse_i) begin
      // a larger code taking effect mid-period still ends the period
      if (st_r.count >= last) begin
        st_nxt.count = '0;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.count = st_r.count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign tick_o = st_r.tick;

endmodule : tick_prescaler

// [verilog/symctr_clock_irq.sv]
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "symctr_defines.svh"

module symctr_clock_irq #(
  parameter int BACKOFF_SYMBOLS = `BACKOFF_SLOT_SYMBOLS,
  parameter int PRESCALE_DIV_MAX = `PRESCALE_DIV_MAX
) (
  // clock, reset, clock enable
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // register port
  input wire logic [`SYMCTR_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // time bases, all synchronous to clk_i
  input wire logic xtal_pulse_i,
  input wire logic rtc_tick_i,
  input wire logic ext_clock_pin_i,
  input wire logic trx_sleep_i,
  // counter core events
  input wire logic counter_low_write_i,
  input wire logic counter_loaded_i,
  input wire logic counter_wrap_i,
  input wire logic [2:0] compare_match_i,
  // interrupt controller handshake, one pulse per vector entered
  input wire symctr_pkg::irq_vec_t irq_entry_i,
  // symbol tick to the counter core and selected source
  output logic symbol_tick_o,
  output symctr_pkg::tick_src_t tick_src_o,
  // control bits seen by the rest of the counter
  output symctr_pkg::ctrl_t ctrl_o,
  output logic counter_write_pending_o,
  // interrupt requests
  output logic backoff_irq_o,
  output logic overflow_irq_o,
  output logic compare3_irq_o,
  output logic compare2_irq_o,
  output logic compare1_irq_o
);
  import symctr_pkg::*;

  localparam int SLOT_W = $clog2(BACKOFF_SYMBOLS);

  typedef struct packed {
    ctrl_t ctrl;
    irq_vec_t irq_mask;
    irq_vec_t irq_status;
    irq_vec_t irq_req;
    logic write_pending;
    logic [SLOT_W-1:0] slot_count;
    logic ext_pin_prev;
    logic symbol_tick;
    tick_src_t tick_src;
    logic [7:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  reg_req_t req;
  logic presc_tick;
  logic ext_rise;
  logic sel_tick;
  tick_src_t src;
  irq_vec_t events;
  irq_vec_t sw_clear;
  irq_vec_t ack_clear;
  logic [7:0] ctrl_rd;
  logic [7:0] status_rd;
  logic [7:0] mask_rd;
  logic [7:0] irqs_rd;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  tick_prescaler #(
    .DIV_MAX(PRESCALE_DIV_MAX)
  ) u_prescaler (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .xtal_pulse_i(xtal_pulse_i),
    .code_i(st_r.ctrl.tick_prescale_code),
    .tick_o(presc_tick)
  );

  // the pin is taken as synchronous, so a plain edge detector suffices;
  // it needs the pin no faster than half of clk_i to see every edge
  assign ext_rise = ext_clock_pin_i & ~st_r.ext_pin_prev;

  // source choice: external wins outright, then RTC by select or sleep
  always_comb begin
    if (st_r.ctrl.ext_clock_enable) begin
      src = SRC_EXT;
    end else if (st_r.ctrl.clock_source_select) begin
      src = SRC_RTC;
    end else if (trx_sleep_i) begin
      src = SRC_RTC;
    end else begin
      src = SRC_XTAL;
    end
  end

  always_comb begin
    unique case (src)
      SRC_EXT: begin
        sel_tick = ext_rise;
      end
      SRC_RTC: begin
        sel_tick = rtc_tick_i;
      end
      SRC_XTAL: begin
        sel_tick = presc_tick;
      end
      default: begin
        sel_tick = 1'b0;
      end
    endcase
  end

  // event sources, one bit each in status order
  always_comb begin
    events = '0;
    events.compare1 = compare_match_i[0];
    events.compare2 = compare_match_i[1];
    events.compare3 = compare_match_i[2];
    events.overflow = counter_wrap_i;
    events.backoff = 1'b0;
    if (st_r.ctrl.backoff_enable && sel_tick) begin
      if (st_r.slot_count == SLOT_W'(BACKOFF_SYMBOLS - 1)) begin
        events.backoff = 1'b1;
      end
    end
  end

  // clears from software writes of one and from vector entry
  always_comb begin
    sw_clear = '0;
    if (req.wr && req.addr == `SYMCTR_ADDR_IRQ_STATUS) begin
      sw_clear = irq_vec_t'(req.wdata[`IRQ_COUNT-1:0]);
    end
    ack_clear = irq_entry_i & st_r.irq_req;
  end

  // read views; reserved bits read as zero
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`CTRL_BACKOFF_EN_BIT] = st_r.ctrl.backoff_enable;
    ctrl_rd[`CTRL_EXT_CLK_EN_BIT] = st_r.ctrl.ext_clock_enable;
    ctrl_rd[`CTRL_PRESCALE_MSB:`CTRL_PRESCALE_LSB] = st_r.ctrl.tick_prescale_code;
    ctrl_rd[`CTRL_CLK_SRC_SEL_BIT] = st_r.ctrl.clock_source_select;
    status_rd = 8'h00;
    status_rd[`STATUS_WRITE_PENDING_BIT] = st_r.write_pending;
    mask_rd = {3'h0, st_r.irq_mask};
    irqs_rd = {3'h0, st_r.irq_status};
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.ext_pin_prev = ext_clock_pin_i;
    st_nxt.symbol_tick = sel_tick;
    st_nxt.tick_src = src;

    // register writes; reserved positions are dropped
    if (req.wr) begin
      unique case (req.addr)
        `SYMCTR_ADDR_CTRL: begin
          st_nxt.ctrl.backoff_enable = req.wdata[`CTRL_BACKOFF_EN_BIT];
          st_nxt.ctrl.ext_clock_enable = req.wdata[`CTRL_EXT_CLK_EN_BIT];
          st_nxt.ctrl.tick_prescale_code = req.wdata[`CTRL_PRESCALE_MSB:`CTRL_PRESCALE_LSB];
          st_nxt.ctrl.clock_source_select = req.wdata[`CTRL_CLK_SRC_SEL_BIT];
        end
        `SYMCTR_ADDR_IRQ_MASK: begin
          st_nxt.irq_mask = irq_vec_t'(req.wdata[`IRQ_COUNT-1:0]);
        end
        default: begin
        end
      endcase
    end

    // backoff slot counter only runs while enabled, restarts on enable
    if (!st_r.ctrl.backoff_enable) begin
      st_nxt.slot_count = '0;
    end else if (sel_tick) begin
      if (st_r.slot_count == SLOT_W'(BACKOFF_SYMBOLS - 1)) begin
        st_nxt.slot_count = '0;
      end else begin
        st_nxt.slot_count = st_r.slot_count + 1'b1;
      end
    end

    // pending write: a new low-byte write in the load cycle keeps it set
    if (counter_low_write_i) begin
      st_nxt.write_pending = 1'b1;
    end else if (counter_loaded_i) begin
      st_nxt.write_pending = 1'b0;
    end

    // events always land in status, mask or not; set beats clear
    st_nxt.irq_status = (st_r.irq_status & ~(sw_clear | ack_clear)) | events;

    // request follows next status and mask, so enabling a set flag fires
    st_nxt.irq_req = st_nxt.irq_status & st_nxt.irq_mask;

    // read data stands for the one cycle after the strobe only
    st_nxt.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        `SYMCTR_ADDR_CTRL: begin
          st_nxt.rdata = ctrl_rd;
        end
        `SYMCTR_ADDR_STATUS: begin
          st_nxt.rdata = status_rd;
        end
        `SYMCTR_ADDR_IRQ_MASK: begin
          st_nxt.rdata = mask_rd;
        end
        `SYMCTR_ADDR_IRQ_STATUS: begin
          st_nxt.rdata = irqs_rd;
        end
        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= '0;
      st_r.ctrl.tick_prescale_code <= `PRESCALE_RESET;
      st_r.irq_mask <= `IRQ_MASK_RESET;
      st_r.irq_status <= `IRQ_STATUS_RESET;
      st_r.tick_src <= SRC_XTAL;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_o = st_r.rdata;
  assign symbol_tick_o = st_r.symbol_tick;
  assign tick_src_o = st_r.tick_src;
  assign ctrl_o = st_r.ctrl;
  assign counter_write_pending_o = st_r.write_pending;
  assign backoff_irq_o = st_r.irq_req.backoff;
  assign overflow_irq_o = st_r.irq_req.overflow;
  assign compare3_irq_o = st_r.irq_req.compare3;
  assign compare2_irq_o = st_r.irq_req.compare2;
  assign compare1_irq_o = st_r.irq_req.compare1;

endmodule : symctr_clock_irq

// [sim/symctr_clock_irq_props.sv]
`timescale 1ns/1ps
module symctr_clock_irq_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // time bases and events
  input wire logic ext_clock_pin_i,
  input wire logic trx_sleep_i,
  input wire logic counter_low_write_i,
  input wire logic counter_loaded_i,
  input wire logic counter_wrap_i,
  input wire symctr_pkg::irq_vec_t irq_entry_i,
  // outputs watched
  input wire logic symbol_tick_o,
  input wire symctr_pkg::tick_src_t tick_src_o,
  input wire symctr_pkg::ctrl_t ctrl_o,
  input wire logic counter_write_pending_o,
  input wire logic overflow_irq_o
);
  import symctr_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  AST_PEND_SET: assert property (ce_i && counter_low_write_i |=> counter_write_pending_o)
    else $error("pending flag missing");
  AST_PEND_CLR: assert property (ce_i && counter_loaded_i && !counter_low_write_i |=> !counter_write_pending_o)
    else $error("pending flag stuck");
  AST_RD_STATUS: assert property (ce_i && reg_rd_i && reg_addr_i == 8'hDE
    |=> reg_rdata_o == {7'h00, $past(counter_write_pending_o)}) else $error("status read wrong");
  AST_RD_IDLE: assert property (ce_i && !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not idle");
  // a write may move the source on the same edge, so those edges are left out
  AST_SRC_EXT: assert property (ce_i && !reg_wr_i && ctrl_o.ext_clock_enable |=> tick_src_o == SRC_EXT)
    else $error("external source not used");
  AST_SRC_RTC: assert property (ce_i && !reg_wr_i && !ctrl_o.ext_clock_enable
    && (ctrl_o.clock_source_select || trx_sleep_i) |=> tick_src_o == SRC_RTC) else $error("rtc source not used");
  AST_EXT_TICK: assert property (ce_i && $past(ce_i) && tick_src_o == SRC_EXT && $rose(ext_clock_pin_i)
    |=> symbol_tick_o) else $error("external edge lost");
  AST_OVF_ENTRY: assert property (ce_i && overflow_irq_o && irq_entry_i.overflow && !counter_wrap_i
    |=> !overflow_irq_o) else $error("entry did not clear");
  AST_OVF_HOLD: assert property (ce_i && overflow_irq_o && !irq_entry_i.overflow && !reg_wr_i
    |=> overflow_irq_o) else $error("request dropped");
  COV_OVF: cover property (counter_wrap_i ##1 overflow_irq_o);
  COV_EXT: cover property (tick_src_o == SRC_EXT ##1 symbol_tick_o);
  COV_PEND: cover property (counter_write_pending_o ##1 !counter_write_pending_o);
endmodule : symctr_clock_irq_props

bind symctr_clock_irq symctr_clock_irq_props u_symctr_clock_irq_props (.clk_i(clk_i), .srst_i(srst_i),
  .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .ext_clock_pin_i(ext_clock_pin_i), .trx_sleep_i(trx_sleep_i), .counter_low_write_i(counter_low_write_i),
  .counter_loaded_i(counter_loaded_i), .counter_wrap_i(counter_wrap_i), .irq_entry_i(irq_entry_i),
  .symbol_tick_o(symbol_tick_o), .tick_src_o(tick_src_o), .ctrl_o(ctrl_o),
  .counter_write_pending_o(counter_write_pending_o), .overflow_irq_o(overflow_irq_o));

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  import symctr_pkg::*;
  logic clk_i = 1'h0;
  logic srst_i = 1'h1;
  logic ce_i = 1'h1;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic reg_wr_i = 1'h0, reg_rd_i = 1'h0, xtal_pulse_i = 1'h0, rtc_tick_i = 1'h0, ext_clock_pin_i = 1'h0;
  logic trx_sleep_i = 1'h0, counter_low_write_i = 1'h0, counter_loaded_i = 1'h0, counter_wrap_i = 1'h0;
  logic [2:0] compare_match_i = 3'h0;
  irq_vec_t irq_entry_i = 5'h00;
  logic symbol_tick_o, counter_write_pending_o;
  logic backoff_irq_o, overflow_irq_o, compare3_irq_o, compare2_irq_o, compare1_irq_o;
  tick_src_t tick_src_o;
  ctrl_t ctrl_o;
  wire [4:0] irqs = {backoff_irq_o, overflow_irq_o, compare3_irq_o, compare2_irq_o, compare1_irq_o};
  int err_total = 0;
  int num_checks = 0;

  symctr_clock_irq u_symctr_clock_irq (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .xtal_pulse_i(xtal_pulse_i), .rtc_tick_i(rtc_tick_i), .ext_clock_pin_i(ext_clock_pin_i),
    .trx_sleep_i(trx_sleep_i), .counter_low_write_i(counter_low_write_i), .counter_loaded_i(counter_loaded_i),
    .counter_wrap_i(counter_wrap_i), .compare_match_i(compare_match_i), .irq_entry_i(irq_entry_i),
    .symbol_tick_o(symbol_tick_o), .tick_src_o(tick_src_o), .ctrl_o(ctrl_o),
    .counter_write_pending_o(counter_write_pending_o), .backoff_irq_o(backoff_irq_o),
    .overflow_irq_o(overflow_irq_o), .compare3_irq_o(compare3_irq_o), .compare2_irq_o(compare2_irq_o),
    .compare1_irq_o(compare1_irq_o));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge clk_i);
    reg_wr_i <= 1'h0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge clk_i);
    reg_rd_i <= 1'h0;
    #1;
    chk(reg_rdata_o, e, m);
  endtask : rd

  // one-cycle event pulse: 0..2 compare units, 3 wrap, 4 low write, 5 loaded, else rtc tick
  task automatic ev(input int k);
    @(posedge clk_i);
    case (k)
      0, 1, 2: compare_match_i[k] <= 1'h1;
      3: counter_wrap_i <= 1'h1;
      4: counter_low_write_i <= 1'h1;
      5: counter_loaded_i <= 1'h1;
      default: rtc_tick_i <= 1'h1;
    endcase
    @(posedge clk_i);
    {compare_match_i, counter_wrap_i, counter_low_write_i, counter_loaded_i, rtc_tick_i} <= 7'h00;
    #1;
  endtask : ev

  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (symbol_tick_o !== 1'h1 && n < 600);
    if (n >= 600) begin
      err_total++;
      tally_and_finish();
    end
  endtask : gap

  task automatic t_reset();
    chk(ctrl_o, 6'h00, "ctrl reset");
    rd(8'hDF, 8'h00, "mask reset");
    rd(8'hE0, 8'h00, "flags reset");
    wr(8'hDF, 8'h1F);
    rd(8'hDF, 8'h1F, "mask bits");
    rd(8'h10, 8'h00, "unmapped read");
    wr(8'hDF, 8'h00);
    $display("done reset");
  endtask : t_reset

  task automatic t_prescale();
    int n;
    xtal_pulse_i <= 1'h1;
    // code 7 is undefined and falls back to the fastest division
    for (int c = 0; c < 8; c++) begin
      wr(8'hDD, 8'(c << 2));
      gap(n);
      gap(n);
      chk(n, (c == 7) ? 4 : (256 >> c), "tick period");
    end
    xtal_pulse_i <= 1'h0;
    wr(8'hDD, 8'h00);
    $display("done prescale");
  endtask : t_prescale

  task automatic t_events();
    for (int i = 0; i < 4; i++) begin
      ev(i);
      rd(8'hE0, 8'(1 << i), "flag set");
      chk(irqs, 5'h00, "masked request");
      wr(8'hE0, 8'h1F ^ 8'(1 << i));
      wr(8'hDF, 8'(1 << i));
      chk(irqs, 32'(1 << i), "request at enable");
      @(posedge clk_i);
      irq_entry_i <= irq_vec_t'(5'(1 << i));
      @(posedge clk_i);
      irq_entry_i <= 5'h00;
      #1;
      chk(irqs, 5'h00, "entry clear");
      wr(8'hDF, 8'h00);
    end
    $display("done events");
  endtask : t_events

  task automatic t_backoff();
    wr(8'hDD, 8'h41);
    repeat (19) ev(6);
    rd(8'hE0, 8'h00, "slot early");
    ev(6);
    repeat (3) @(posedge clk_i);
    rd(8'hE0, 8'h10, "slot flag");
    chk(tick_src_o, SRC_RTC, "rtc select");
    rd(8'hDD, 8'h41, "ctrl readback");
    wr(8'hDF, 8'h10);
    chk(irqs, 5'h10, "slot request");
    wr(8'hE0, 8'h10);
    chk(irqs, 5'h00, "slot cleared");
    wr(8'hDF, 8'h00);
    wr(8'hDD, 8'h00);
    $display("done backoff");
  endtask : t_backoff

  task automatic t_source();
    int cnt;
    wr(8'hDD, 8'h18);
    trx_sleep_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    #1;
    chk(tick_src_o, SRC_RTC, "sleep fallback");
    wr(8'hDD, 8'h1A);
    repeat (2) @(posedge clk_i);
    #1;
    chk(tick_src_o, SRC_EXT, "ext in sleep");
    cnt = 0;
    for (int k = 0; k < 20; k++) begin
      @(posedge clk_i);
      ext_clock_pin_i <= (k % 4 >= 2) && (k < 16); // pin at a quarter of clk
      #1;
      cnt += symbol_tick_o;
    end
    chk(cnt, 4, "ext ticks");
    trx_sleep_i <= 1'h0;
    wr(8'hDD, 8'h00);
    $display("done source");
  endtask : t_source

  task automatic t_pending();
    // only the status register is polled while the write is pending
    ev(4);
    rd(8'hDE, 8'h01, "busy set");
    rd(8'hDE, 8'h01, "busy held");
    ev(5);
    rd(8'hDE, 8'h00, "busy cleared");
    // a low clock enable must swallow the event
    @(posedge clk_i);
    ce_i <= 1'h0;
    ev(4);
    ce_i <= 1'h1;
    rd(8'hDE, 8'h00, "frozen by enable");
    $display("done pending");
  endtask : t_pending

  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'h0;
    #1;
    t_reset();
    t_prescale();
    t_events();
    t_backoff();
    t_source();
    t_pending();
    tally_and_finish();
  end
endmodule : tb
